// ---- rtl/bsp_pkg.sv ----
// bsp_pkg: constants and types for the boot self-program flash sequencer
// assumes: single 50 MHz clock, synchronous active-high reset
package bsp_pkg;
	// program counter and page layout
	localparam int COUNTER_TOP_BIT = 12;
	localparam int WORD_INDEX_TOP_BIT = 5;
	localparam int POINTER_COUNTER_TOP_BIT = 13;
	localparam int POINTER_WORD_INDEX_TOP_BIT = 6;
	localparam int PAGE_WORDS = 64;
	localparam int PAGE_COUNT = 128;
	// region limits
	localparam logic [12:0] BLOCKED_REGION_START = 13'h1C00;
	localparam logic [12:0] BOOT_START_128 = 13'h1F80;
	localparam logic [12:0] BOOT_START_256 = 13'h1F00;
	localparam logic [12:0] BOOT_START_512 = 13'h1E00;
	localparam logic [12:0] BOOT_START_1024 = 13'h1C00;
	// register offsets on the plain port
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_POINTER_LO = 4'h1;
	localparam logic [3:0] OFS_POINTER_HI = 4'h2;
	localparam logic [3:0] OFS_DATA_LO = 4'h3;
	localparam logic [3:0] OFS_DATA_HI = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;
	// control register bit positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_WRITE = 2;
	localparam int BIT_REENABLE = 4;
	localparam int BIT_BUSY = 6;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// timing
	localparam int CLK_MHZ = 50;
	localparam int ARM_WINDOW_CYCLES = 4;
	localparam int PROG_TIME_US = 4500;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int REENABLE_CYCLES = 1;

	typedef enum logic [2:0] {
		BSP_IDLE = 3'b000,
		BSP_ARMED = 3'b001,
		BSP_ERASE = 3'b010,
		BSP_WRITE = 3'b011,
		BSP_FILL = 3'b100,
		BSP_REEN = 3'b101
	} bsp_state_e;

	// page number from pointer bits 13..7
	function automatic logic [6:0] bsp_page_of(input logic [15:0] p);
		return p[POINTER_COUNTER_TOP_BIT:POINTER_WORD_INDEX_TOP_BIT+1];
	endfunction : bsp_page_of

	// word index from pointer bits 6..1
	function automatic logic [5:0] bsp_word_of(input logic [15:0] p);
		return p[POINTER_WORD_INDEX_TOP_BIT:1];
	endfunction : bsp_word_of
endpackage : bsp_pkg

// ---- rtl/bsp_buf_if.sv ----
// bsp_buf_if: write/read port of the temporary page buffer
// assumes: one clock, driven by the sequencer only
`timescale 1ns/1ps
`default_nettype none
interface bsp_buf_if;
	logic wr_en;
	logic [5:0] wr_addr;
	logic [15:0] wr_data;
	logic [5:0] rd_addr;
	logic [15:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface : bsp_buf_if
`default_nettype wire

// ---- rtl/bsp_page_buf.sv ----
// bsp_page_buf: 64-word temporary page buffer, registered read data
// assumes: sys_clk_i shared with the sequencer
`timescale 1ns/1ps
`default_nettype none
module bsp_page_buf
	import bsp_pkg::*;
(
	input wire logic sys_clk_i,
	bsp_buf_if.mem bus
);
	logic [15:0] mem [PAGE_WORDS];
	// write then registered read
	always_ff @(posedge sys_clk_i)
	begin
		if (bus.wr_en)
			mem[bus.wr_addr] <= bus.wr_data;
		bus.rd_data <= mem[bus.rd_addr];
	end
endmodule : bsp_page_buf
`default_nettype wire

// ---- rtl/bsp_flash_seq.sv ----
// bsp_flash_seq: self-programming sequencer for on-chip program flash
// assumes: cpu drives the plain register port and pulses spm_exec_i
// What this block and its software do
// (R1) program counter is 13 bits, words 0x0000 to 0x1FFF
// (R2) page holds 64 words: word index pc 5..0, page pc 12..6
// (R3) counter bit n maps to pointer bit n+1
// (R4) erase and write take page from pointer bits 13..7
// (R5) pointer bits 6..1 select buffer word; zero on page write
// (R6) pointer bits 15..14 are ignored
// (R7) pointer bit 0 is ignored on load and for flash writes
// (R8) boot size setting picks 128..1024 word region ending at 0x1FFF
// (R9) readable region 0x0000-0x1BFF, blocked region 0x1C00-0x1FFF
// (R10) during erase or write only blocked region code is fetchable
// (R11) software waits for enable bit zero before new command
// (R12) software waits for eeprom write idle before writing control
// (R13) software disables interrupts around the timed write
// (R14) erase plus enable then write instruction erases pointer page
// (R15) enable alone stores r1:r0 into buffer at pointer word
// (R16) write plus enable then instruction programs buffer into page
// (R17) busy flag reads one until re-enable command clears it
// (R18) routine issuing the write instruction lives in boot region
// (R19) write instruction within four cycles or command discarded
// (R20) eeprom write in progress blocks all flash programming
// (R21) enable bit clears when the operation completes
// (R22) busy set at erase/write start, held until re-enable done
`timescale 1ns/1ps
`default_nettype none
module bsp_flash_seq
	import bsp_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic spm_exec_i,
	input wire logic eeprom_write_active_i,
	input wire logic [1:0] boot_region_size_setting_i,
	input wire logic [12:0] fetch_addr_i,
	output logic fetch_allow_o,
	output logic [12:0] boot_start_o,
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic [6:0] flash_page_o,
	output logic [5:0] flash_word_o,
	output logic [15:0] flash_data_o,
	input wire logic flash_done_i
);
	typedef struct packed {
		bsp_state_e st;
		logic [7:0] ctrl;
		logic [15:0] ptr;
		logic [15:0] data;
		logic [2:0] win;
		logic [22:0] tmr;
		logic [7:0] rdata;
		logic [6:0] page;
		logic [5:0] word;
		logic busy;
		logic erase;
		logic write;
	} bsp_state_s;

	bsp_state_s s_reg, s_next;
	bsp_buf_if bif ();

	bsp_page_buf u_buf (
		.sys_clk_i(sys_clk_i),
		.bus(bif.mem)
	);

	// boot start address from the size setting
	function automatic logic [12:0] boot_start(input logic [1:0] sz);
		case (sz)
			2'b11: return BOOT_START_128; // R8
			2'b10: return BOOT_START_256;
			2'b01: return BOOT_START_512;
			default: return BOOT_START_1024;
		endcase
	endfunction : boot_start

	// sequencer next state
	always_comb
	begin
		s_next = s_reg;
		s_next.erase = 1'b0;
		s_next.write = 1'b0;
		s_next.rdata = 8'h00;
		// register reads, data one cycle later
		if (rd_i)
		begin
			case (addr_i)
				OFS_CONTROL: s_next.rdata = {s_reg.ctrl[7], s_reg.busy,
					s_reg.ctrl[5:0]}; // R17
				OFS_POINTER_LO: s_next.rdata = s_reg.ptr[7:0];
				OFS_POINTER_HI: s_next.rdata = s_reg.ptr[15:8];
				OFS_DATA_LO: s_next.rdata = s_reg.data[7:0];
				OFS_DATA_HI: s_next.rdata = s_reg.data[15:8];
				OFS_STATUS: s_next.rdata = {5'h00, s_reg.st};
				default: s_next.rdata = 8'h00;
			endcase
		end
		// register writes
		if (wr_i)
		begin
			case (addr_i)
				OFS_POINTER_LO: s_next.ptr[7:0] = wdata_i;
				OFS_POINTER_HI: s_next.ptr[15:8] = wdata_i;
				OFS_DATA_LO: s_next.data[7:0] = wdata_i;
				OFS_DATA_HI: s_next.data[15:8] = wdata_i;
				OFS_CONTROL:
					// eeprom write blocks command; busy bit is read-only
					if (s_reg.st == BSP_IDLE && !eeprom_write_active_i
						&& wdata_i[BIT_ENABLE]) // R20
					begin
						s_next.ctrl = {wdata_i[7], 1'b0, wdata_i[5:0]};
						s_next.st = BSP_ARMED;
						s_next.win = 3'(ARM_WINDOW_CYCLES);
					end
				default: ;
			endcase
		end
		case (s_reg.st)
			BSP_IDLE: ;
			BSP_ARMED:
			begin
				if (spm_exec_i)
				begin
					// pointer bits 15..14 ignored, bit 0 ignored
					s_next.page = bsp_page_of(s_reg.ptr); // R4 R6 R3
					s_next.word = bsp_word_of(s_reg.ptr); // R5 R7
					if (s_reg.ctrl[BIT_ERASE])
					begin
						s_next.st = BSP_ERASE; // R14
						s_next.erase = 1'b1;
						s_next.busy = 1'b1; // R22
						s_next.tmr = 23'(PROG_CYCLES_P);
					end
					else if (s_reg.ctrl[BIT_WRITE])
					begin
						s_next.st = BSP_WRITE; // R16
						s_next.busy = 1'b1; // R22
						s_next.word = 6'h00;
						s_next.tmr = 23'(PAGE_WORDS);
					end
					else if (s_reg.ctrl[BIT_REENABLE])
						s_next.st = BSP_REEN;
					else
						s_next.st = BSP_FILL; // R15
				end
				else if (s_reg.win == 3'h1)
				begin
					s_next.st = BSP_IDLE; // R19
					s_next.ctrl = CONTROL_RESET;
				end
				else
					s_next.win = s_reg.win - 3'h1;
			end
			BSP_FILL:
			begin
				s_next.st = BSP_IDLE;
				s_next.ctrl = CONTROL_RESET; // R21
			end
			BSP_ERASE:
			begin
				if (s_reg.tmr != 23'h0)
					s_next.tmr = s_reg.tmr - 23'h1;
				if (flash_done_i || s_reg.tmr == 23'h1)
				begin
					s_next.st = BSP_IDLE;
					s_next.ctrl = CONTROL_RESET; // R21
				end
			end
			BSP_WRITE:
			begin
				// stream buffer words out, one per cycle
				s_next.write = s_reg.tmr != 23'h0;
				if (s_reg.tmr != 23'h0)
				begin
					s_next.tmr = s_reg.tmr - 23'h1;
					s_next.word = s_reg.word + 6'h1;
				end
				else
				begin
					s_next.st = BSP_IDLE;
					s_next.ctrl = CONTROL_RESET; // R21
				end
			end
			BSP_REEN:
			begin
				s_next.busy = 1'b0; // R17 R22
				s_next.st = BSP_IDLE;
				s_next.ctrl = CONTROL_RESET; // R21
			end
			default: s_next.st = BSP_IDLE;
		endcase
	end

	// buffer port
	always_comb
	begin
		bif.wr_en = s_reg.st == BSP_ARMED && spm_exec_i
			&& s_reg.ctrl[3:1] == 3'h0 && !s_reg.ctrl[BIT_REENABLE]; // R15
		bif.wr_addr = bsp_word_of(s_reg.ptr); // R5
		bif.wr_data = s_reg.data;
		bif.rd_addr = s_reg.word;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			s_reg <= '0;
			s_reg.st <= BSP_IDLE;
		end
		else
			s_reg <= s_next;
	end

	// fetch gating and outputs
	always_comb
	begin
		// blocked region only while busy
		fetch_allow_o = !s_reg.busy
			|| fetch_addr_i >= BLOCKED_REGION_START; // R9 R10 R1
		boot_start_o = boot_start(boot_region_size_setting_i); // R8
	end

	assign rdata_o = s_reg.rdata;
	assign flash_erase_o = s_reg.erase;
	assign flash_write_o = s_reg.write;
	assign flash_page_o = s_reg.page; // R2
	assign flash_word_o = s_reg.word - 6'h1;
	assign flash_data_o = bif.rd_data;
endmodule : bsp_flash_seq
`default_nettype wire

// ---- dv/bsp_flash_model.sv ----
// bsp_flash_model: program flash array on the far side of the sequencer
// assumes: erase done pulse dly_i cycles after erase, 0 means never
`timescale 1ns/1ps
`default_nettype none
module bsp_flash_model (
	input wire logic sys_clk_i,
	input wire logic erase_i,
	input wire logic write_i,
	input wire logic [6:0] page_i,
	input wire logic [5:0] word_i,
	input wire logic [15:0] data_i,
	input wire logic [7:0] dly_i,
	output logic done_o
);
	logic [15:0] mem [0:8191];
	logic [7:0] cnt = 8'h00;
	initial done_o = 1'b0;
	// erase blanks the page, a write stream stores each word
	always @(posedge sys_clk_i)
	begin
		done_o <= cnt == 8'h01;
		if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
		if (erase_i)
			cnt <= dly_i;
		for (int i = 0; i < 64; i++)
			if (erase_i)
				mem[{page_i, 6'(i)}] <= 16'hFFFF;
		if (write_i)
			mem[{page_i, word_i}] <= data_i;
	end
endmodule : bsp_flash_model
`default_nettype wire

// ---- dv/bsp_flash_seq_properties.sv ----
// bsp_flash_seq_properties: port checks of the flash sequencer
// assumes: bound to bsp_flash_seq, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module bsp_flash_seq_properties (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic wr_i,
	input wire logic spm_exec_i,
	input wire logic eeprom_write_active_i,
	input wire logic [1:0] boot_region_size_setting_i,
	input wire logic [12:0] fetch_addr_i,
	input wire logic fetch_allow_o,
	input wire logic [12:0] boot_start_o,
	input wire logic flash_erase_o,
	input wire logic flash_write_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [12:0] exp_start;
	logic [6:0] len_reg;
	// region of 128 << (3 - setting) words below the top
	assign exp_start = 13'(14'h2000 -
		(14'h0080 << (2'h3 - boot_region_size_setting_i)));
	// length of the running page write stream
	always_ff @(posedge sys_clk_i)
		len_reg <= (rst_i || !flash_write_o) ? 7'h00 : len_reg + 7'h01;
	sequence s_ee_cmd;
		wr_i && addr_i == 4'h0 && eeprom_write_active_i ##1 spm_exec_i;
	endsequence
	sequence s_late;
		!wr_i [*5] ##1 spm_exec_i;
	endsequence
	chk_boot_start: assert property (boot_start_o == exp_start)
		else $error("boot start wrong");
	chk_top_fetch: assert property (
		fetch_addr_i >= 13'h1C00 |-> fetch_allow_o)
		else $error("top region fetch blocked");
	chk_low_block: assert property (
		(flash_erase_o || flash_write_o) && fetch_addr_i < 13'h1C00
		|-> !fetch_allow_o) else $error("low fetch open");
	chk_erase_cause: assert property (
		flash_erase_o |-> $past(spm_exec_i)) else $error("stray erase");
	chk_erase_pulse: assert property (
		flash_erase_o |=> !flash_erase_o) else $error("long erase");
	chk_write_len: assert property (
		$fell(flash_write_o) |-> len_reg == 7'h40)
		else $error("write stream length");
	chk_ee_refuse: assert property (s_ee_cmd |=>
		!flash_erase_o && !$rose(flash_write_o)) else $error("ee ignored");
	chk_late_exec: assert property (s_late |=>
		!flash_erase_o && !$rose(flash_write_o)) else $error("late exec");
endmodule : bsp_flash_seq_properties
`default_nettype wire

// ---- dv/tb.sv ----
// tb: self-checking bench of the flash sequencer
// assumes: flash array model on the far side, short program time
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bsp_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, spm = 1'b0;
	logic ee = 1'b0, al, fe, fw, done;
	logic [3:0] a = 4'h0;
	logic [7:0] wd = 8'h00, dly = 8'h00, rdat, d;
	logic [1:0] bsz = 2'h0;
	logic [12:0] fa = 13'h0000, bst;
	logic [6:0] pg;
	logic [5:0] wo;
	logic [15:0] fd;
	int miscompares = 0, check_count = 0;
	initial forever #10 clk = ~clk;
	bsp_flash_seq #(.PROG_CYCLES_P(20)) i_dut (.sys_clk_i(clk), .rst_i(rst),
		.addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
		.spm_exec_i(spm), .eeprom_write_active_i(ee),
		.boot_region_size_setting_i(bsz), .fetch_addr_i(fa),
		.fetch_allow_o(al), .boot_start_o(bst), .flash_erase_o(fe),
		.flash_write_o(fw), .flash_page_o(pg), .flash_word_o(wo),
		.flash_data_o(fd), .flash_done_i(done));
	bsp_flash_model i_mem (.sys_clk_i(clk), .erase_i(fe), .write_i(fw),
		.page_i(pg), .word_i(wo), .data_i(fd), .dly_i(dly), .done_o(done));
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task automatic wreg(input logic [3:0] ad, input logic [7:0] v);
		@(posedge clk);
		a <= ad;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg;
		@(posedge clk);
		a <= OFS_CONTROL;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask : rreg
	// control write, then the write instruction one cycle later
	task automatic cmd(input logic [7:0] v);
		wreg(OFS_CONTROL, v);
		spm <= 1'b1;
		@(posedge clk);
		spm <= 1'b0;
	endtask : cmd
	task automatic poll;
		repeat (300)
		begin
			rreg;
			if (d[BIT_ENABLE] === 1'b0)
				break;
		end
		cmp(16'(d[BIT_ENABLE]), 16'h0000);
	endtask : poll
	task automatic setp(input logic [15:0] z);
		wreg(OFS_POINTER_LO, z[7:0]);
		wreg(OFS_POINTER_HI, z[15:8]);
	endtask : setp
	task automatic t_map;
		logic [12:0] st [4] = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk);
			bsz <= 2'(s);
			#1 cmp(16'(bst), 16'(st[s]));
		end
	endtask : t_map
	task automatic t_erase;
		fa <= 13'h0100;
		setp(16'hC280);
		cmd(8'h03);
		rreg;
		cmp(16'(d[BIT_BUSY]), 16'h0001);
		cmp(16'(al), 16'h0000);
		@(posedge clk);
		fa <= 13'h1C40;
		@(posedge clk);
		#1 cmp(16'(al), 16'h0001);
		@(posedge clk);
		fa <= 13'h0100;
		poll;
		cmp(i_mem.mem[13'h0149], 16'hFFFF);
		cmd(8'h11);
		rreg;
		cmp(16'(d[BIT_BUSY]), 16'h0000);
		cmp(16'(al), 16'h0001);
	endtask : t_erase
	task automatic t_write;
		dly <= 8'h03;
		setp(16'h0300);
		cmd(8'h03);
		poll;
		cmd(8'h11);
		for (int w = 0; w < 64; w++)
		begin
			setp({9'h006, 6'(w), 1'b0});
			wreg(OFS_DATA_LO, {2'b00, 6'(w)});
			wreg(OFS_DATA_HI, {2'b11, 6'(w)});
			cmd(8'h01);
			poll;
		end
		setp(16'h0300);
		cmd(8'h05);
		poll;
		for (int w = 0; w < 64; w++)
			cmp(i_mem.mem[{7'h06, 6'(w)}], {2'b11, 6'(w), 2'b00, 6'(w)});
		cmd(8'h11);
	endtask : t_write
	task automatic t_refuse;
		ee <= 1'b1;
		setp(16'h0400);
		cmd(8'h03);
		rreg;
		cmp(16'(d), 16'h0000);
		ee <= 1'b0;
		wreg(OFS_CONTROL, 8'h03);
		repeat (6) @(posedge clk);
		spm <= 1'b1;
		@(posedge clk);
		spm <= 1'b0;
		rreg;
		cmp(16'(d), 16'h0000);
		cmp(i_mem.mem[13'h0200], 16'hXXXX);
	endtask : t_refuse
	task automatic test_done;
		$display("mismatches %0d of %0d checks", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rreg;
		cmp(16'(d), 16'(CONTROL_RESET));
		t_map;
		t_erase;
		t_write;
		t_refuse;
		test_done;
	end
	// cut a hang short
	initial
	begin
		#500000;
		miscompares++;
		test_done;
	end
endmodule : tb
bind bsp_flash_seq bsp_flash_seq_properties i_chk (.sys_clk_i(sys_clk_i),
	.rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .spm_exec_i(spm_exec_i),
	.eeprom_write_active_i(eeprom_write_active_i),
	.boot_region_size_setting_i(boot_region_size_setting_i),
	.fetch_addr_i(fetch_addr_i), .fetch_allow_o(fetch_allow_o),
	.boot_start_o(boot_start_o), .flash_erase_o(flash_erase_o),
	.flash_write_o(flash_write_o));
`default_nettype wire
